//--- design/hp_device_end.sv
// Device end: bus style detection and register access decoding.
`timescale 1ns/10ps
module hp_device_end
    import hp_pkg::*;
#(
    parameter int DETECT_CYC = DETECT_CYCLES
) (
    input  wire logic                  core_clk,
    input  wire logic                  sys_rst,
    input  wire logic                  ded_common_strobe,
    hp_if.dev                          link,
    output logic                       reg_rd_pulse,
    output logic                       reg_wr_pulse,
    output logic [MUX_ADDR_W-1:0]      reg_addr,
    output logic [DATA_W-1:0]          reg_wdata,
    input  wire logic [DATA_W-1:0]     reg_rdata,
    output bus_mode_type               mode_out,
    output logic                       detect_done
);

    // ****************************************************************
    // Pin synchronisers.
    // ****************************************************************
    localparam int PW = DATA_W + 7;

    typedef enum logic [4:0] {
        ST_DETECT = 5'h01,
        ST_IDLE   = 5'h02,
        ST_READ   = 5'h04,
        ST_WRITE  = 5'h08,
        ST_ADDR   = 5'h10
    } dev_state_type;

    logic [PW-1:0]         pin_raw;
    logic [PW-1:0]         s1_q;
    logic [PW-1:0]         s2_q;
    logic [PW-1:0]         s3_q;
    logic [PW-1:0]         pin_q;
    logic [PW-1:0]         prev_q;
    logic [DATA_W-1:0]     data_f;
    logic                  cs_f;
    logic                  rd_f;
    logic                  wr_f;
    logic                  latch_f;
    logic                  latch_prev;
    logic                  a2_f;
    logic                  a1_f;
    logic                  a0_f;
    logic [7:0]            det_cnt_q;
    bus_mode_type          mode_q;
    dev_state_type         state_q;
    logic                  sep;
    logic                  com;
    logic                  hs;
    logic                  mux;
    logic                  rd_go;
    logic                  wr_go;
    logic                  addr_go;
    logic                  strobe_idle;
    logic [MUX_ADDR_W-1:0] addr_q;
    logic [DATA_W-1:0]     wdata_q;
    logic                  rd_pulse_q;
    logic                  wr_pulse_q;
    logic [DATA_W-1:0]     rdata_q;
    logic                  rdata_oe_n_q;
    logic                  wait_en_q;
    logic                  wait_q;

    assign pin_raw = {link.muxed_addr_data_bus, link.chip_select_n,
                      link.read_strobe_n, link.write_strobe_n,
                      link.addr_strobe_hi, link.addr_pin_2,
                      link.addr_pin_1, link.addr_pin_0};

    // Every pin is foreign to core_clk, so it passes three stages and a
    // change is taken only once stages two and three agree.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            s1_q   <= '1;
            s2_q   <= '1;
            s3_q   <= '1;
            pin_q  <= '1;
            prev_q <= '1;
        end else begin
            s1_q   <= pin_raw;
            s2_q   <= s1_q;
            s3_q   <= s2_q;
            prev_q <= pin_q;
            for (int i = 0; i < PW; i++) begin
                pin_q[i] <= agree_bit(s2_q[i], s3_q[i], pin_q[i]);
            end
        end
    end

    assign data_f     = pin_q[PW-1:7];
    assign cs_f       = pin_q[6];
    assign rd_f       = pin_q[5];
    assign wr_f       = pin_q[4];
    assign latch_f    = pin_q[3];
    assign latch_prev = prev_q[3];
    assign a2_f       = pin_q[2];
    assign a1_f       = pin_q[1];
    assign a0_f       = pin_q[0];

    // ****************************************************************
    // Bus style detection.
    // ****************************************************************

    // Decodes the strap pattern seen once the pins have settled.
    function automatic bus_mode_type decode_mode(input logic latch,
                                                 input logic a2,
                                                 input logic a1,
                                                 input logic a0,
                                                 input logic cs,
                                                 input logic com_sel);
        if (!latch && !a2 && a1) begin
            decode_mode = a0 ? MODE_SEP_MUX : MODE_COM_MUX;
        end else if (latch && a2 && a1 && !cs) begin
            decode_mode = MODE_HANDSHAKE;
        end else if (latch) begin
            decode_mode = com_sel ? MODE_COM_DED : MODE_SEP_DED;
        end else begin
            decode_mode = MODE_UNKNOWN;
        end
    endfunction : decode_mode

    // Reset throws away the old style; after the settle count the straps
    // are read once and the result is frozen until the next reset, so a
    // host toggling address pins later cannot change the style.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            det_cnt_q <= 8'h00;
            mode_q    <= MODE_UNKNOWN;
        end else if (state_q == ST_DETECT) begin
            if (det_cnt_q == 8'(DETECT_CYC - 1)) begin
                mode_q <= decode_mode(latch_f, a2_f, a1_f, a0_f, cs_f,
                                      ded_common_strobe);
            end else begin
                det_cnt_q <= det_cnt_q + 8'h01;
            end
        end
    end

    assign sep = (mode_q == MODE_SEP_DED) || (mode_q == MODE_SEP_MUX);
    assign com = (mode_q == MODE_COM_DED) || (mode_q == MODE_COM_MUX);
    assign hs  = (mode_q == MODE_HANDSHAKE);
    assign mux = (mode_q == MODE_SEP_MUX) || (mode_q == MODE_COM_MUX);

    // ****************************************************************
    // Access decoding.
    // ****************************************************************

    // Data strobes are only looked at while chip select is low; in the
    // handshake style that same gating inhibits the data strobe.
    always_comb begin
        rd_go   = 1'b0;
        wr_go   = 1'b0;
        addr_go = 1'b0;
        if (sep) begin
            rd_go = !cs_f && !rd_f;
            wr_go = !cs_f && !wr_f && rd_f;
        end else if (com || hs) begin
            rd_go = !cs_f && !rd_f && wr_f;
            wr_go = !cs_f && !rd_f && !wr_f;
        end
        if (hs) begin
            addr_go = !latch_f && !wr_f;
        end
    end

    assign strobe_idle = cs_f || (sep ? (rd_f && wr_f) : rd_f);

    // Access sequencer; an address strobe with the write pin high would
    // be an address read and is simply never answered.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_q <= ST_DETECT;
        end else begin
            case (state_q)
                ST_DETECT: begin
                    if (det_cnt_q == 8'(DETECT_CYC - 1)) begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_IDLE: begin
                    if (addr_go) begin
                        state_q <= ST_ADDR;
                    end else if (rd_go) begin
                        state_q <= ST_READ;
                    end else if (wr_go) begin
                        state_q <= ST_WRITE;
                    end
                end
                ST_READ, ST_WRITE: begin
                    if (strobe_idle) begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_ADDR: begin
                    if (latch_f) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_DETECT;
                end
            endcase
        end
    end

    // Register address capture for all styles.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            addr_q <= '0;
        end else if (mux && latch_f) begin
            addr_q <= data_f[MUX_ADDR_W-1:0];
        end else if (state_q == ST_ADDR && !latch_f) begin
            addr_q <= data_f[MUX_ADDR_W-1:0];
        end else if (!mux && !hs && state_q == ST_IDLE && (rd_go || wr_go))
        begin
            addr_q <= {3'h0, a2_f, a1_f, a0_f};
        end
    end

    // Write data is followed while the strobe is active and handed on
    // with a one-cycle pulse once the strobe ends.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wdata_q    <= '0;
            wr_pulse_q <= 1'b0;
        end else begin
            wr_pulse_q <= (state_q == ST_WRITE) && strobe_idle;
            if (state_q == ST_WRITE && !strobe_idle) begin
                wdata_q <= data_f;
            end
        end
    end

    // Read: a pulse at the start, then the bus is driven from a flop
    // that follows the register data for the whole strobe.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rd_pulse_q   <= 1'b0;
            rdata_q      <= '0;
            rdata_oe_n_q <= 1'b1;
        end else begin
            rd_pulse_q   <= (state_q == ST_IDLE) && !addr_go && rd_go;
            rdata_oe_n_q <= !((state_q == ST_READ) && !strobe_idle);
            if (state_q == ST_READ) begin
                rdata_q <= reg_rdata;
            end
        end
    end

    // ****************************************************************
    // Handshake wait output.
    // ****************************************************************

    // Address pin 0 stays released after reset; it becomes the wait
    // output at the first falling address strobe, since before then
    // the pin may still be an ordinary strap.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wait_en_q <= 1'b0;
            wait_q    <= 1'b0;
        end else begin
            if (hs && state_q != ST_DETECT && latch_prev && !latch_f) begin
                wait_en_q <= 1'b1;
            end
            wait_q <= hs && ((state_q == ST_READ) || (state_q == ST_WRITE)
                             || (state_q == ST_ADDR));
        end
    end

    assign link.wait_out      = wait_q;
    assign link.wait_oe_n     = !wait_en_q;
    assign link.dev_data_out  = rdata_q;
    assign link.dev_data_oe_n = rdata_oe_n_q;
    assign reg_rd_pulse       = rd_pulse_q;
    assign reg_wr_pulse       = wr_pulse_q;
    assign reg_addr           = addr_q;
    assign reg_wdata          = wdata_q;
    assign mode_out           = mode_q;
    assign detect_done        = (state_q != ST_DETECT);

endmodule : hp_device_end

//--- design/hp_pkg.sv
// Shared constants, types and helpers of the auto-detecting host port.
//
// Notes on behaviour
// - Reset clears mode and restarts bus detection.
// - Mode comes from strapped control pin levels.
// - Host data path is eight bits wide.
// - Separate strobes, dedicated bus: latch tied high.
// - Address pin 2 low, 1 high: multiplexed.
// - Address pin 0 picks separate or common strobe; dedicated bus uses ded_common_strobe.
// - Common strobe: write pin is read-not-write.
// - Handshake: pins 2,1 high, select low.
// - Handshake uses write, data, address strobes, wait.
// - Six-bit muxed address, three-bit dedicated address.
// - Chip select gates handshake data strobe.
// - Wait output released until first address strobe.
// - Handshake address read cycle is never used.
// - Address latched while latch high, strobe low.
// - Wait low starts, high ends an access.
// - Data strobes count only while chip select low.
package hp_pkg;

    // ****************************************************************
    // Widths and timing.
    // ****************************************************************
    localparam int DATA_W            = 8;
    localparam int MUX_ADDR_W        = 6;
    localparam int DED_ADDR_W        = 3;
    localparam int CLK_PERIOD_NS     = 10;
    localparam int DETECT_NS         = 80;
    localparam int DETECT_CYCLES     = DETECT_NS / CLK_PERIOD_NS;
    localparam int HOST_PHASE_NS     = 160;
    localparam int HOST_PHASE_CYCLES = HOST_PHASE_NS / CLK_PERIOD_NS;
    localparam logic [DATA_W-1:0] BUS_IDLE = 8'hFF;

    // ****************************************************************
    // Bus styles, one-hot.
    // ****************************************************************
    typedef enum logic [5:0] {
        MODE_UNKNOWN   = 6'h01,
        MODE_SEP_DED   = 6'h02,
        MODE_SEP_MUX   = 6'h04,
        MODE_COM_DED   = 6'h08,
        MODE_COM_MUX   = 6'h10,
        MODE_HANDSHAKE = 6'h20
    } bus_mode_type;

    // A filtered pin follows only once the second and third stages agree.
    function automatic logic agree_bit(input logic s2,
                                       input logic s3,
                                       input logic held);
        agree_bit = (s2 == s3) ? s3 : held;
    endfunction : agree_bit

endpackage : hp_pkg

//--- design/hp_if.sv
// Pin-level carrier joining the host end and the device end.
`timescale 1ns/10ps
interface hp_if;
    import hp_pkg::*;

    // Pins driven only by the host.
    logic              read_strobe_n;
    logic              write_strobe_n;
    logic              chip_select_n;
    logic              addr_strobe_hi;
    logic              addr_pin_1;
    logic              addr_pin_2;
    logic              addr_pin_0_out;
    logic              addr_pin_0_oe_n;
    logic [DATA_W-1:0] host_data_out;
    logic              host_data_oe_n;
    // Pins driven by the device.
    logic              wait_out;
    logic              wait_oe_n;
    logic [DATA_W-1:0] dev_data_out;
    logic              dev_data_oe_n;
    // Resolved wire levels; an undriven wire reads as pulled high.
    logic              addr_pin_0;
    logic [DATA_W-1:0] muxed_addr_data_bus;

    assign addr_pin_0 = !addr_pin_0_oe_n ? addr_pin_0_out :
                        !wait_oe_n       ? wait_out : 1'b1;
    assign muxed_addr_data_bus = !dev_data_oe_n  ? dev_data_out  :
                                 !host_data_oe_n ? host_data_out : BUS_IDLE;

    modport dev (
        input  read_strobe_n, write_strobe_n, chip_select_n,
        input  addr_strobe_hi, addr_pin_1, addr_pin_2, addr_pin_0,
        input  muxed_addr_data_bus,
        output wait_out, wait_oe_n, dev_data_out, dev_data_oe_n
    );

    modport host (
        output read_strobe_n, write_strobe_n, chip_select_n,
        output addr_strobe_hi, addr_pin_1, addr_pin_2,
        output addr_pin_0_out, addr_pin_0_oe_n,
        output host_data_out, host_data_oe_n,
        input  addr_pin_0, muxed_addr_data_bus
    );
endinterface : hp_if

//--- design/hp_host_end.sv
// Host end: drives one fixed bus style and runs register accesses.
`timescale 1ns/10ps
module hp_host_end
    import hp_pkg::*;
#(
    parameter bus_mode_type MODE  = MODE_SEP_DED,
    parameter int           PHASE = HOST_PHASE_CYCLES
) (
    input  wire logic                  core_clk,
    input  wire logic                  sys_rst,
    input  wire logic                  cmd_valid,
    input  wire logic                  cmd_write,
    input  wire logic [MUX_ADDR_W-1:0] cmd_addr,
    input  wire logic [DATA_W-1:0]     cmd_wdata,
    output logic                       cmd_ready,
    output logic                       rsp_valid,
    output logic [DATA_W-1:0]          rsp_rdata,
    hp_if.host                         link
);

    typedef enum logic [4:0] {
        H_IDLE   = 5'h01,
        H_ADDR   = 5'h02,
        H_SETUP  = 5'h04,
        H_STROBE = 5'h08,
        H_RECOV  = 5'h10
    } host_state_type;

    localparam bit SEP = (MODE == MODE_SEP_DED) || (MODE == MODE_SEP_MUX);
    localparam bit HS  = (MODE == MODE_HANDSHAKE);
    localparam bit MUX = (MODE == MODE_SEP_MUX) || (MODE == MODE_COM_MUX)
                         || HS;
    localparam bit DED = !MUX;

    host_state_type        state_q;
    logic [7:0]            cnt_q;
    logic [MUX_ADDR_W-1:0] a_q;
    logic                  w_q;
    logic [DATA_W-1:0]     wd_q;
    logic [DATA_W:0]       s1_q;
    logic [DATA_W:0]       s2_q;
    logic [DATA_W:0]       s3_q;
    logic [DATA_W:0]       in_q;
    logic                  wait_f;
    logic                  phase_done;
    logic                  step;
    logic                  strobe_on;
    logic                  rsp_q;
    logic [DATA_W-1:0]     rdata_q;

    // ****************************************************************
    // Input synchronisers for the wait pin and the data bus.
    // ****************************************************************
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            s1_q <= '1;
            s2_q <= '1;
            s3_q <= '1;
            in_q <= '1;
        end else begin
            s1_q <= {link.addr_pin_0, link.muxed_addr_data_bus};
            s2_q <= s1_q;
            s3_q <= s2_q;
            for (int i = 0; i <= DATA_W; i++) begin
                in_q[i] <= agree_bit(s2_q[i], s3_q[i], in_q[i]);
            end
        end
    end

    assign wait_f     = in_q[DATA_W];
    assign phase_done = (cnt_q == 8'(PHASE - 1));

    // Each phase lasts at least PHASE cycles; with the handshake the
    // strobe phases also wait for wait high and the gaps for wait low.
    always_comb begin
        case (state_q)
            H_ADDR, H_STROBE: step = phase_done && (!HS || wait_f);
            H_SETUP, H_RECOV: step = phase_done && (!HS || !wait_f);
            default:          step = 1'b0;
        endcase
    end

    // ****************************************************************
    // Access sequencer.
    // ****************************************************************
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_q <= H_IDLE;
            cnt_q   <= 8'h00;
            a_q     <= '0;
            w_q     <= 1'b0;
            wd_q    <= '0;
            rsp_q   <= 1'b0;
            rdata_q <= '0;
        end else begin
            rsp_q <= 1'b0;
            if (step || (state_q == H_IDLE)) begin
                cnt_q <= 8'h00;
            end else if (!phase_done) begin
                cnt_q <= cnt_q + 8'h01;
            end
            case (state_q)
                H_IDLE: begin
                    if (cmd_valid) begin
                        a_q     <= cmd_addr;
                        w_q     <= cmd_write;
                        wd_q    <= cmd_wdata;
                        state_q <= MUX ? H_ADDR : H_SETUP;
                    end
                end
                H_ADDR: if (step) state_q <= H_SETUP;
                H_SETUP: if (step) state_q <= H_STROBE;
                H_STROBE: begin
                    if (step) begin
                        rdata_q <= in_q[DATA_W-1:0];
                        state_q <= H_RECOV;
                    end
                end
                H_RECOV: begin
                    if (step) begin
                        rsp_q   <= 1'b1;
                        state_q <= H_IDLE;
                    end
                end
                default: state_q <= H_IDLE;
            endcase
        end
    end

    // ****************************************************************
    // Pin drivers; straps are driven from reset so detection sees them.
    // ****************************************************************
    assign strobe_on = (state_q == H_STROBE);

    always_ff @(posedge core_clk) begin
        link.chip_select_n  <= HS ? 1'b0 :
                              !((state_q == H_SETUP) || strobe_on);
        link.addr_strobe_hi <= DED ? 1'b1 :
                              HS ? (state_q != H_ADDR) :
                              (state_q == H_ADDR);
        link.addr_pin_2     <= DED ? a_q[2] : HS;
        link.addr_pin_1     <= DED ? a_q[1] : 1'b1;
        link.addr_pin_0_out <= DED ? a_q[0] : (MODE == MODE_SEP_MUX);
        link.addr_pin_0_oe_n <= HS;
        link.read_strobe_n  <= SEP ? !(strobe_on && !w_q) : !strobe_on;
        link.write_strobe_n <= SEP ? !(strobe_on && w_q) :
                              !((HS && state_q == H_ADDR) ||
                                (w_q && state_q != H_IDLE));
        if (MUX && state_q == H_ADDR) begin
            link.host_data_out  <= {2'h0, a_q};
            link.host_data_oe_n <= 1'b0;
        end else begin
            link.host_data_out  <= wd_q;
            link.host_data_oe_n <= !(w_q && state_q != H_IDLE
                                     && state_q != H_ADDR);
        end
    end

    assign cmd_ready = (state_q == H_IDLE);
    assign rsp_valid = rsp_q;
    assign rsp_rdata = rdata_q;

endmodule : hp_host_end

//--- tb/hp_link_properties.sv
// Concurrent checks on the link joining the host end and the device end.
`timescale 1ns/10ps
module hp_link_properties
    import hp_pkg::*;
(
    input wire logic    core_clk,
    input wire logic    sys_rst,
    input wire logic    chip_select_n,
    input wire logic    wait_oe_n,
    input wire logic    dev_data_oe_n,
    input wire logic    reg_rd_pulse,
    input wire logic    reg_wr_pulse,
    input wire logic    detect_done,
    input bus_mode_type mode_out
);
    // ********
    // Assertions, all in the core clock domain.
    // ********
    // Reset state is judged at the first edge after release, not during it.
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    a_release_idle: assert property (
        $fell(sys_rst) |-> wait_oe_n && dev_data_oe_n && !detect_done
        && mode_out == MODE_UNKNOWN) else $error("link busy at release");
    a_detect_time: assert property (
        $fell(sys_rst) |-> !detect_done [*8] ##[1:12] detect_done)
        else $error("detection not on time");
    a_mode_known: assert property (
        detect_done |-> $onehot(mode_out) && mode_out != MODE_UNKNOWN)
        else $error("detected mode not a bus style");
    a_mode_holds: assert property (
        detect_done |=> $stable(mode_out) && detect_done)
        else $error("detected mode changed");
    a_idle_select: assert property (
        chip_select_n [*8] |-> !reg_rd_pulse && !reg_wr_pulse)
        else $error("access without chip select");
    a_read_drives: assert property (
        reg_rd_pulse |=> !dev_data_oe_n) else $error("read data not driven");
    a_bus_after_done: assert property (
        (!dev_data_oe_n || reg_wr_pulse) |-> detect_done)
        else $error("bus used before detection");
    a_wait_mode: assert property (
        mode_out != MODE_HANDSHAKE |-> wait_oe_n)
        else $error("wait driven outside handshake");
endmodule : hp_link_properties

//--- tb/tb_top.sv
// Self-checking bench joining a multiplexed host end to the device end.
`timescale 1ns/10ps
module tb_top;
    import hp_pkg::*;
    logic         core_clk, sys_rst, cmd_valid, cmd_write, cmd_ready;
    logic         rsp_valid, ded_common_strobe, reg_rd_pulse, reg_wr_pulse;
    logic         detect_done, cmd_busy;
    logic [5:0]   cmd_addr, reg_addr, cur_addr;
    logic [7:0]   cmd_wdata, rsp_rdata, reg_wdata, reg_rdata;
    logic [13:0]  exp_w;
    logic [7:0]   ref_mem [64];
    logic [7:0]   dev_mem [64];
    logic [13:0]  wr_q [$];
    logic [5:0]   rd_q [$];
    bus_mode_type mode_out;
    int           n_errors, n_checks, cycles;
    hp_if link();
    hp_host_end #(.MODE(MODE_SEP_MUX), .PHASE(HOST_PHASE_CYCLES)) i_hp_host_end (
        .core_clk(core_clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
        .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
        .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .link(link));
    hp_device_end #(.DETECT_CYC(DETECT_CYCLES)) i_hp_device_end (
        .core_clk(core_clk), .sys_rst(sys_rst),
        .ded_common_strobe(ded_common_strobe), .link(link),
        .reg_rd_pulse(reg_rd_pulse), .reg_wr_pulse(reg_wr_pulse),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .mode_out(mode_out), .detect_done(detect_done));
    hp_link_properties chk (.core_clk(core_clk), .sys_rst(sys_rst),
        .chip_select_n(link.chip_select_n), .wait_oe_n(link.wait_oe_n),
        .dev_data_oe_n(link.dev_data_oe_n), .reg_rd_pulse(reg_rd_pulse),
        .reg_wr_pulse(reg_wr_pulse), .detect_done(detect_done),
        .mode_out(mode_out));
    // ********
    // Clock, compare and closing tasks.
    // ********
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task automatic compare_byte(string what, logic [7:0] e, logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask : compare_byte
    task automatic compare_mode(string what, bus_mode_type e, bus_mode_type g);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask : compare_mode
    task automatic complete_run();
        if (n_errors == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : complete_run
    // Reset, then wait a bounded time for detection and check the straps.
    task automatic do_reset();
        sys_rst = 1'b1;
        repeat (16) @(negedge core_clk);
        compare_mode("mode in reset", MODE_UNKNOWN, mode_out);
        sys_rst = 1'b0;
        for (int k = 0; k < 40 && detect_done !== 1'b1; k++) begin
            @(negedge core_clk);
        end
        compare_byte("detect done", 8'h01, {7'h00, detect_done});
        compare_mode("mode", MODE_SEP_MUX, mode_out);
        compare_byte("straps", 8'h03, {5'h00, link.addr_pin_2,
            link.addr_pin_1, link.addr_pin_0});
        compare_byte("wait oe", 8'h01, {7'h00, link.wait_oe_n});
    endtask : do_reset
    // One host command; the bench memory is the expected register file.
    task automatic run_cmd(logic wr, logic [5:0] a, logic [7:0] d);
        while (cmd_ready !== 1'b1) @(negedge core_clk);
        {cmd_valid, cmd_write, cmd_addr, cmd_wdata} = {1'b1, wr, a, d};
        {cur_addr, cmd_busy} = {a, 1'b1};
        if (wr) begin
            wr_q.push_back({a, d});
            ref_mem[a] = d;
        end else begin
            rd_q.push_back(a);
        end
        @(negedge core_clk);
        cmd_valid = 1'b0;
        while (rsp_valid !== 1'b1) @(negedge core_clk);
        if (!wr) compare_byte("read data", ref_mem[a], rsp_rdata);
        cmd_busy = 1'b0;
    endtask : run_cmd
    // Register side monitor; an unexpected access finds an empty queue.
    always @(negedge core_clk) begin
        reg_rdata <= dev_mem[reg_addr];
        if (cmd_busy && link.addr_strobe_hi === 1'b1)
            compare_byte("latched addr", {2'b00, cur_addr},
                {2'b00, link.muxed_addr_data_bus[5:0]});
        if (reg_wr_pulse === 1'b1) begin
            compare_byte("wr expected", 8'h01, {7'h00, wr_q.size() > 0});
            exp_w = wr_q.size() > 0 ? wr_q.pop_front() : 14'h0000;
            compare_byte("wr addr", {2'b00, exp_w[13:8]}, {2'b00, reg_addr});
            compare_byte("wr data", exp_w[7:0], reg_wdata);
            dev_mem[reg_addr] <= reg_wdata;
        end
        if (reg_rd_pulse === 1'b1) begin
            compare_byte("rd expected", 8'h01, {7'h00, rd_q.size() > 0});
            compare_byte("rd addr", {2'b00, rd_q.size() > 0 ? rd_q.pop_front()
                : 6'h00}, {2'b00, reg_addr});
        end
    end
    // Hang guard: a run of about 3000 cycles gets a generous ceiling.
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            complete_run();
        end
    end
    // ********
    // Main sequence.
    // ********
    initial begin
        {sys_rst, cmd_valid, cmd_write, cmd_addr, cmd_wdata} = 17'h10000;
        {ded_common_strobe, cmd_busy, reg_rdata} = 10'h000;
        {n_errors, n_checks, cycles} = '0;
        void'($urandom(57));
        for (int i = 0; i < 64; i++) begin
            ref_mem[i] = 8'($urandom);
            dev_mem[i] = ref_mem[i];
        end
        @(negedge core_clk);
        do_reset();
        run_cmd(1'b1, 6'h00, 8'hFF);
        run_cmd(1'b1, 6'h3F, 8'h00);
        run_cmd(1'b0, 6'h3F, 8'h00);
        run_cmd(1'b0, 6'h00, 8'h00);
        for (int i = 0; i < 40; i++) begin
            ded_common_strobe = 1'(i);
            run_cmd(1'($urandom), 6'($urandom), 8'($urandom));
            compare_mode("held mode", MODE_SEP_MUX, mode_out);
            if (i == 30) do_reset();
        end
        compare_byte("writes left", 8'h00, 8'(wr_q.size()));
        complete_run();
    end
endmodule : tb_top
